// ---- rtl/ftcfg_regs.sv ----
// Fan tach pulse-count and temperature format / overtemperature configuration registers
`timescale 1ns/100ps
`default_nettype none
module ftcfg_regs #(
    parameter bit HYST_VARIANT = 1'b0
) (
    // APB clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Shared pin function and raw temperatures and limits (same clock)
    input  wire logic [1:0]  shared_pin_function_sel,
    input  wire logic [7:0]  onchip_temp,
    input  wire logic [7:0]  remote_a_temp,
    input  wire logic [7:0]  remote_b_temp,
    input  wire logic [7:0]  onchip_limit,
    input  wire logic [7:0]  remote_a_limit,
    input  wire logic [7:0]  remote_b_limit,
    // General-purpose pin
    input  wire logic        gp_pin_in,
    output logic             gp_pin_out,
    output logic             gp_pin_oe,
    output logic             gp_pin_level,
    // Overtemperature pin, open drain, active low
    input  wire logic        overtemp_pin_in,
    output logic             overtemp_pin_out,
    output logic             overtemp_pin_oe,
    output logic             overtemp_timer_in,
    // Configuration seen by the rest of the chip
    output logic [2:0]       tach1_pulse_count,
    output logic [2:0]       tach2_pulse_count,
    output logic [2:0]       tach3_pulse_count,
    output logic [2:0]       tach4_pulse_count,
    output logic             signed_temp_format_sel,
    output logic             offset_range_wide,
    output logic             overtemp_hyst_enable
);
    import ftcfg_pkg::*;

    logic [7:0] tach_sel_r;
    logic [7:0] temp_cfg_r;
    logic       lock_r;
    logic [1:0] gp_sync_r;
    logic [1:0] ot_sync_r;
    logic       ot_drive_r;
    logic [2:0] ot_hit_r;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr_idx;
    logic       gp_enabled;
    logic [2:0] ot_hit_nxt;
    logic [7:0] cfg_wmask;

    // Zero-wait slave: every access completes in its first access cycle
    assign pready   = 1'b1;
    assign addr_idx = paddr[9:2];
    assign wr_en    = psel && penable && pwrite && (paddr[1:0] == 2'b00) && pstrb[0];
    // Read data is fetched in the setup cycle so it already stands through the access cycle
    assign rd_en    = psel && !penable && !pwrite;
    // Unmapped words answer with an error rather than a silent zero
    assign pslverr  = psel && penable && (paddr[11:10] != 2'b00 ||
                      (addr_idx != FTCFG_TACH_SEL_IDX && addr_idx != FTCFG_TEMP_CFG_IDX &&
                       addr_idx != FTCFG_LOCK_CTRL_IDX && addr_idx != FTCFG_STATUS_IDX));

    // Hysteresis bit is writable only on the variant that has it
    assign cfg_wmask = HYST_VARIANT ? 8'hff : 8'hef;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tach_sel_r <= FTCFG_TACH_SEL_RST;
        end else if (wr_en && !pslverr && addr_idx == FTCFG_TACH_SEL_IDX) begin
            tach_sel_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            temp_cfg_r <= FTCFG_TEMP_CFG_RST;
        end else if (wr_en && !pslverr && addr_idx == FTCFG_TEMP_CFG_IDX && !lock_r) begin
            temp_cfg_r <= pwdata[7:0] & cfg_wmask;
        end
    end

    // Lock is sticky until reset, so software cannot reopen the config
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_r <= 1'b0;
        end else if (wr_en && !pslverr && addr_idx == FTCFG_LOCK_CTRL_IDX && pwdata[0]) begin
            lock_r <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            case (addr_idx)
                FTCFG_TACH_SEL_IDX:  prdata <= {24'h00_0000, tach_sel_r};
                FTCFG_TEMP_CFG_IDX:  prdata <= {24'h00_0000, temp_cfg_r};
                FTCFG_LOCK_CTRL_IDX: prdata <= {31'h0000_0000, lock_r};
                FTCFG_STATUS_IDX:    prdata <= {24'h00_0000, 2'b00, gp_sync_r[1],
                                                ot_sync_r[1], ot_drive_r, ot_hit_r};
                default:             prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Pulse codes 0..3 map to 1..4 counted pulses
    assign tach1_pulse_count = {1'b0, tach_sel_r[FTCFG_TACH1_LSB +: 2]} + 3'd1;
    assign tach2_pulse_count = {1'b0, tach_sel_r[FTCFG_TACH2_LSB +: 2]} + 3'd1;
    assign tach3_pulse_count = {1'b0, tach_sel_r[FTCFG_TACH3_LSB +: 2]} + 3'd1;
    assign tach4_pulse_count = {1'b0, tach_sel_r[FTCFG_TACH4_LSB +: 2]} + 3'd1;

    assign signed_temp_format_sel = temp_cfg_r[FTCFG_FMT_BIT];
    assign offset_range_wide      = temp_cfg_r[FTCFG_RANGE_BIT];
    assign overtemp_hyst_enable   = temp_cfg_r[FTCFG_HYST_BIT];

    // Pins come from outside the clock domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gp_sync_r <= 2'b00;
            ot_sync_r <= 2'b11;
        end else begin
            gp_sync_r <= {gp_sync_r[0], gp_pin_in};
            ot_sync_r <= {ot_sync_r[0], overtemp_pin_in};
        end
    end

    assign gp_enabled   = (shared_pin_function_sel == FTCFG_PINFN_GPIO);
    assign gp_pin_oe    = gp_enabled && temp_cfg_r[FTCFG_GPDIR_BIT];
    // Drive level follows polarity: low-active drives 0 when asserted
    assign gp_pin_out   = temp_cfg_r[FTCFG_GPPOL_BIT];
    assign gp_pin_level = gp_sync_r[1];

    // Comparison under the current format, so a format flip acts at once
    function automatic logic ot_exceeds(input logic [7:0] t, input logic [7:0] lim,
                                        input logic twos);
        logic       off;
        logic [7:0] mn;
        off = 1'b0;
        mn  = twos ? FTCFG_LIM_MIN_TWOS : FTCFG_LIM_MIN_OFS64;
        if (lim == mn) begin
            off = 1'b1;
        end
        if (twos) begin
            ot_exceeds = !off && ($signed(t) > $signed(lim));
        end else begin
            ot_exceeds = !off && (t > lim);
        end
    endfunction

    always_comb begin
        ot_hit_nxt[0] = temp_cfg_r[FTCFG_LOCAL_BIT] &&
                        ot_exceeds(onchip_temp, onchip_limit, signed_temp_format_sel);
        ot_hit_nxt[1] = temp_cfg_r[FTCFG_REMA_BIT] &&
                        ot_exceeds(remote_a_temp, remote_a_limit, signed_temp_format_sel);
        ot_hit_nxt[2] = temp_cfg_r[FTCFG_REMB_BIT] &&
                        ot_exceeds(remote_b_temp, remote_b_limit, signed_temp_format_sel);
    end

    // Registered so the open-drain enable never glitches on compare edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ot_hit_r   <= 3'b000;
            ot_drive_r <= 1'b0;
        end else begin
            ot_hit_r   <= ot_hit_nxt;
            ot_drive_r <= |ot_hit_nxt;
        end
    end

    assign overtemp_pin_out  = 1'b0;
    assign overtemp_pin_oe   = ot_drive_r;
    // Timer sees the pin only while we are not pulling it ourselves
    assign overtemp_timer_in = !ot_sync_r[1] && !ot_drive_r;
endmodule // ftcfg_regs
`default_nettype wire

// ---- rtl/ftcfg_pkg.sv ----
// Package of offsets, fields, reset values and codes for the fan tach and temperature config block
package ftcfg_pkg;
    localparam logic [7:0]  FTCFG_TACH_SEL_IDX    = 8'h7b;
    localparam logic [7:0]  FTCFG_TEMP_CFG_IDX    = 8'h7c;
    localparam logic [7:0]  FTCFG_LOCK_CTRL_IDX   = 8'h70;
    localparam logic [7:0]  FTCFG_STATUS_IDX      = 8'h71;
    localparam logic [7:0]  FTCFG_TACH_SEL_RST    = 8'h55;
    localparam logic [7:0]  FTCFG_TEMP_CFG_RST    = 8'h00;
    localparam int          FTCFG_TACH1_LSB       = 0;
    localparam int          FTCFG_TACH2_LSB       = 2;
    localparam int          FTCFG_TACH3_LSB       = 4;
    localparam int          FTCFG_TACH4_LSB       = 6;
    localparam int          FTCFG_FMT_BIT         = 0;
    localparam int          FTCFG_RANGE_BIT       = 1;
    localparam int          FTCFG_GPDIR_BIT       = 2;
    localparam int          FTCFG_GPPOL_BIT       = 3;
    localparam int          FTCFG_HYST_BIT        = 4;
    localparam int          FTCFG_REMA_BIT        = 5;
    localparam int          FTCFG_LOCAL_BIT       = 6;
    localparam int          FTCFG_REMB_BIT        = 7;
    localparam logic [1:0]  FTCFG_PINFN_GPIO      = 2'b10;
    localparam logic [7:0]  FTCFG_LIM_MIN_OFS64   = 8'h00;
    localparam logic [7:0]  FTCFG_LIM_MIN_TWOS    = 8'h80;
    localparam logic [7:0]  FTCFG_OFS64_BIAS      = 8'h40;
endpackage

// ---- tb/ftcfg_regs_chk.sv ----
// Checker of APB answers and configuration outputs
`timescale 1ns/100ps
`default_nettype none
module ftcfg_regs_chk #(parameter bit HYST_VARIANT = 1'b0) (
    // Clock, reset and APB
    input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    // Pin function select and configuration outputs
    input wire logic [1:0]  shared_pin_function_sel,
    input wire logic        gp_pin_oe, signed_temp_format_sel, offset_range_wide,
    input wire logic        overtemp_hyst_enable,
    input wire logic [2:0]  tach1_pulse_count, tach4_pulse_count
);
    import ftcfg_pkg::*;
    logic acc, tach_wr, cfg_wr, mapped;
    assign acc = psel && penable;
    assign tach_wr = acc && pwrite && pstrb[0] && paddr == 12'h1ec;
    assign cfg_wr = acc && pwrite && paddr == 12'h1f0;
    assign mapped = paddr[11:2] inside {10'h070, 10'h071, 10'h07b, 10'h07c};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_now_a: assert property (acc |-> pready) else $error("pready low in access");
    err_map_a: assert property (pslverr == (acc && !mapped)) else $error("pslverr wrong");
    tach_one_a: assert property (tach_wr |=> tach1_pulse_count == {1'b0, $past(pwdata[1:0])} + 3'd1)
        else $error("fan one count wrong");
    tach_four_a: assert property (tach_wr |=> tach4_pulse_count == {1'b0, $past(pwdata[7:6])} + 3'd1)
        else $error("fan four count wrong");
    reset_val_a: assert property ($rose(presetn) |-> tach1_pulse_count == 3'd2 &&
        tach4_pulse_count == 3'd2 && !signed_temp_format_sel && !offset_range_wide) else $error("reset value");
    gp_gate_a: assert property (shared_pin_function_sel != FTCFG_PINFN_GPIO |-> !gp_pin_oe)
        else $error("gp pin driven while not selected");
    cfg_hold_a: assert property (!cfg_wr |=> $stable({signed_temp_format_sel, offset_range_wide}))
        else $error("config changed without write");
    hyst_res_a: assert property (HYST_VARIANT || !overtemp_hyst_enable)
        else $error("reserved bit set");
endmodule // ftcfg_regs_chk
bind ftcfg_regs ftcfg_regs_chk #(.HYST_VARIANT(HYST_VARIANT)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .shared_pin_function_sel(shared_pin_function_sel),
    .gp_pin_oe(gp_pin_oe), .signed_temp_format_sel(signed_temp_format_sel),
    .offset_range_wide(offset_range_wide), .overtemp_hyst_enable(overtemp_hyst_enable),
    .tach1_pulse_count(tach1_pulse_count), .tach4_pulse_count(tach4_pulse_count));
`default_nettype wire

// ---- tb/test_ftcfg_regs.sv ----
// Testbench of the fan tach and temperature config registers
`timescale 1ns/100ps
`default_nettype none
module test_ftcfg_regs;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, gp_out, gp_oe, ot_oe, err;
    logic        fmt, rng, hyst;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0]  pin_fn;
    logic [7:0]  on_t, on_l, ra_t, ra_l;
    logic [2:0]  t1, t2, t3, t4;
    int          error_cnt = 0, num_checks = 0, cyc = 0;
    wire         gp_wire = gp_oe ? gp_out : 1'b1;
    wire         ot_wire = ~ot_oe; // Open drain: pulled up unless driven
    ftcfg_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .shared_pin_function_sel(pin_fn), .onchip_temp(on_t),
        .remote_a_temp(ra_t), .remote_b_temp(8'h00), .onchip_limit(on_l), .remote_a_limit(ra_l),
        .remote_b_limit(8'h7f), .gp_pin_in(gp_wire), .gp_pin_out(gp_out), .gp_pin_oe(gp_oe),
        .gp_pin_level(), .overtemp_pin_in(ot_wire), .overtemp_pin_out(), .overtemp_pin_oe(ot_oe),
        .overtemp_timer_in(), .tach1_pulse_count(t1), .tach2_pulse_count(t2),
        .tach3_pulse_count(t3), .tach4_pulse_count(t4), .signed_temp_format_sel(fmt),
        .offset_range_wide(rng), .overtemp_hyst_enable(hyst));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; answer and read data are taken at the edge that samples pready high
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        err = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic ot(input logic [7:0] cfg, input logic [7:0] lim, input logic exp);
        on_l <= lim;
        apb(1'b1, 12'h1f0, cfg);
        repeat (2) @(posedge pclk);
        chk(ot_oe, exp);
    endtask
    task automatic end_sim;
        $display("Checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            $display("[ERR] %0t timeout", $time);
            end_sim();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pin_fn, ra_t} = '0;
        {on_t, on_l, ra_l} = {8'h60, 8'h7f, 8'h7f};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h1ec, 8'h00); chk(rd, 32'h55);
        apb(1'b0, 12'h1f0, 8'h00); chk(rd, 32'h0);
        chk({t1, t2, t3, t4}, {4{3'd2}});
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, 12'h1ec, {4{c[1:0]}}); chk({t1, t2, t3, t4}, {4{3'(c + 1)}});
        end
        apb(1'b1, 12'h1ec, 8'he4); apb(1'b0, 12'h1ec, 8'h00); chk(rd, 32'he4);
        chk({t4, t3, t2, t1}, {3'd4, 3'd3, 3'd2, 3'd1});
        pin_fn <= 2'b10;
        apb(1'b1, 12'h1f0, 8'hff); apb(1'b0, 12'h1f0, 8'h00); chk(rd, 32'hef);
        chk({fmt, rng, hyst, gp_oe, gp_out}, 5'b11011);
        apb(1'b1, 12'h1f0, 8'h04); chk({gp_oe, gp_out, fmt, rng}, 4'b1000);
        pin_fn <= 2'b00;
        apb(1'b1, 12'h1f0, 8'h0c); chk(gp_oe, 1'b0);
        ot(8'h40, 8'h50, 1'b1);
        ot(8'h40, 8'h00, 1'b0);
        ot(8'h41, 8'h80, 1'b0);
        ot(8'h41, 8'hf0, 1'b1);
        ot(8'h80, 8'h50, 1'b0);
        {ra_t, ra_l} <= {8'h60, 8'h50};
        ot(8'h20, 8'h7f, 1'b1);
        apb(1'b0, 12'h1c4, 8'h00); chk(rd, 32'h2a);
        apb(1'b1, 12'h1f0, 8'h0b); apb(1'b1, 12'h1c0, 8'h01); apb(1'b1, 12'h1f0, 8'h00);
        apb(1'b0, 12'h1f0, 8'h00); chk(rd, 32'h0b);
        apb(1'b0, 12'h004, 8'h00); chk({err, rd}, {1'b1, 32'h0});
        end_sim();
    end
endmodule // test_ftcfg_regs
`default_nettype wire
